// File: pcms_top.v
// port configuration selector: decodes selector plus port configuration write
// assumes classic wishbone master, synchronous pins, single clock clk_i
// Behaviour
// (R1) default selector writes only pin direction
// (R2) software loads selector before non-direction writes
// (R3) decode 0F dir, 0E pull, 0D level, 0C hyst
// (R4) port b wake, swap pending and comparator
// (R5) per-port feature availability enforced
// (R6) command names port and source value
// (R7) direction one input, reset all inputs
// (R8) pull-up one disabled, reset disabled
// (R9) threshold one ttl, reset ttl
// (R10) hysteresis one normal, reset normal
// (R11) selector holds value, resets to direction
`include "pcms_regs.vh"
module pcms_top (
    input wire clk_i,
    input wire rst_i,
    input wire cyc_i,
    input wire stb_i,
    input wire we_i,
    input wire [5:0] adr_i,
    input wire [3:0] sel_i,
    input wire [31:0] dat_i,
    output reg [31:0] dat_o,
    output wire ack_o,
    output wire irq_o,
    input wire [7:0] portb_pin_i,
    output wire [39:0] pin_direction_reg_o,
    output wire [39:0] pullup_reg_o,
    output wire [39:0] threshold_select_reg_o,
    output wire [39:0] noise_immune_input_select_o,
    output wire [7:0] wakeup_enable_portb_o,
    output wire [7:0] wakeup_edge_portb_o,
    output wire [7:0] comparator_ctrl_o
);
    reg ack_ff;
    reg [3:0] mode_sel_ff;
    reg [7:0] acc_ff;
    reg [7:0] wakeup_pending_portb_ff;
    reg [7:0] comp_ff;
    reg [1:0] irq_st_ff;
    reg [1:0] irq_mask_ff;
    reg [7:0] nxt_acc;
    reg [7:0] nxt_pend;
    reg [7:0] nxt_comp;
    reg [1:0] nxt_irq_st;
    reg [31:0] nxt_dat;
    wire bus_req;
    wire wr_stb;
    wire cmd_wr;
    wire [2:0] cmd_port;
    wire [7:0] cmd_src;
    wire [7:0] wake_hit;
    wire [4:0] dir_we;
    wire [4:0] pull_we;
    wire [4:0] lvl_we;
    wire [4:0] hyst_we;
    wire wken_we;
    wire wked_we;
    wire swap_pend;
    wire swap_comp;
    wire bad_cmd;

    function hit;
        input [2:0] port;
        input integer idx;
        input [3:0] msel;
        input [3:0] code;
        begin
            hit = (port == idx) && (msel == code);
        end
    endfunction

    // one-cycle ack; drops in the cycle after it is given
    assign bus_req = cyc_i & stb_i & ~ack_ff;
    assign ack_o = ack_ff;
    assign wr_stb = bus_req & we_i & sel_i[0];
    // command word: bits 10:8 port index, 7:0 source operand
    assign cmd_wr = wr_stb && (adr_i == `PCMS_OFF_CMD); // R6
    assign cmd_port = dat_i[10:8];
    assign cmd_src = dat_i[7:0]; // R6

    genvar gi;
    generate
        for (gi = 0; gi < `PCMS_PORTS; gi = gi + 1) begin : g_port
            assign dir_we[gi] = cmd_wr & hit(cmd_port, gi, mode_sel_ff, `PCMS_SEL_DIR); // R1 R3
            assign pull_we[gi] = cmd_wr & hit(cmd_port, gi, mode_sel_ff, `PCMS_SEL_PULLUP); // R3
            assign lvl_we[gi] = cmd_wr & hit(cmd_port, gi, mode_sel_ff, `PCMS_SEL_LEVEL); // R3
            pcms_cfg_reg #(.RST_VAL(`PCMS_DIR_RST)) u_dir ( // R7
                .clk_i(clk_i),
                .rst_i(rst_i),
                .we_i(dir_we[gi]),
                .d_i(cmd_src),
                .q_o(pin_direction_reg_o[gi*8 +: 8])
            );
            pcms_cfg_reg #(.RST_VAL(`PCMS_PULLUP_RST)) u_pull ( // R8
                .clk_i(clk_i),
                .rst_i(rst_i),
                .we_i(pull_we[gi]),
                .d_i(cmd_src),
                .q_o(pullup_reg_o[gi*8 +: 8])
            );
            pcms_cfg_reg #(.RST_VAL(`PCMS_LEVEL_RST)) u_lvl ( // R9
                .clk_i(clk_i),
                .rst_i(rst_i),
                .we_i(lvl_we[gi]),
                .d_i(cmd_src),
                .q_o(threshold_select_reg_o[gi*8 +: 8])
            );
            if (gi == 0) begin : g_nohyst
                // port a has no hysteresis input; reads as normal
                assign hyst_we[gi] = 1'b0; // R5
                assign noise_immune_input_select_o[7:0] = `PCMS_HYST_RST;
            end else begin : g_hyst
                assign hyst_we[gi] = cmd_wr & hit(cmd_port, gi, mode_sel_ff, `PCMS_SEL_HYST); // R3
                pcms_cfg_reg #(.RST_VAL(`PCMS_HYST_RST)) u_hyst ( // R10
                    .clk_i(clk_i),
                    .rst_i(rst_i),
                    .we_i(hyst_we[gi]),
                    .d_i(cmd_src),
                    .q_o(noise_immune_input_select_o[gi*8 +: 8])
                );
            end
        end
    endgenerate

    // wake and comparator exist on port b only
    assign wken_we = cmd_wr & hit(cmd_port, `PCMS_PORT_B, mode_sel_ff, `PCMS_SEL_WKEN); // R4 R5
    assign wked_we = cmd_wr & hit(cmd_port, `PCMS_PORT_B, mode_sel_ff, `PCMS_SEL_WKED); // R4 R5
    assign swap_pend = cmd_wr & hit(cmd_port, `PCMS_PORT_B, mode_sel_ff, `PCMS_SEL_WKPND); // R4
    assign swap_comp = cmd_wr & hit(cmd_port, `PCMS_PORT_B, mode_sel_ff, `PCMS_SEL_COMP); // R4
    // a command that lands on no register is flagged, not silently lost
    assign bad_cmd = cmd_wr & ~(|dir_we | |pull_we | |lvl_we | |hyst_we | wken_we | wked_we
        | swap_pend | swap_comp); // R2 R4

    pcms_cfg_reg #(.RST_VAL(`PCMS_WKEN_RST)) u_wken (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .we_i(wken_we),
        .d_i(cmd_src),
        .q_o(wakeup_enable_portb_o)
    );
    pcms_cfg_reg #(.RST_VAL(`PCMS_WKED_RST)) u_wked (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .we_i(wked_we),
        .d_i(cmd_src),
        .q_o(wakeup_edge_portb_o)
    );
    pcms_wake_det u_wake (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .pin_i(portb_pin_i),
        .en_n_i(wakeup_enable_portb_o),
        .edge_i(wakeup_edge_portb_o),
        .hit_o(wake_hit)
    );

    always @* begin
        nxt_acc = acc_ff;
        nxt_pend = wakeup_pending_portb_ff;
        nxt_comp = comp_ff;
        if (wr_stb && adr_i == `PCMS_OFF_ACC) begin
            nxt_acc = dat_i[7:0];
        end
        if (swap_pend) begin
            nxt_acc = wakeup_pending_portb_ff; // R4
            nxt_pend = acc_ff;
        end
        if (swap_comp) begin
            nxt_acc = comp_ff; // R4
            nxt_comp = acc_ff & `PCMS_COMP_BITS; // R5
        end
        nxt_pend = nxt_pend | wake_hit;
        nxt_irq_st = irq_st_ff;
        if (wr_stb && adr_i == `PCMS_OFF_IRQ_ST) begin
            nxt_irq_st = irq_st_ff & ~dat_i[1:0];
        end
        // new events win over a same-cycle clear
        nxt_irq_st = nxt_irq_st | {bad_cmd, |wake_hit};
    end

    always @(posedge clk_i) begin
        if (rst_i) begin
            ack_ff <= 1'b0;
            mode_sel_ff <= `PCMS_SEL_RST; // R11
            acc_ff <= 8'h00;
            wakeup_pending_portb_ff <= 8'h00;
            comp_ff <= `PCMS_COMP_RST;
            irq_st_ff <= 2'h0;
            irq_mask_ff <= 2'h0;
            dat_o <= 32'h00000000;
        end else begin
            ack_ff <= bus_req;
            acc_ff <= nxt_acc;
            wakeup_pending_portb_ff <= nxt_pend;
            comp_ff <= nxt_comp;
            irq_st_ff <= nxt_irq_st;
            dat_o <= nxt_dat;
            if (wr_stb && adr_i == `PCMS_OFF_SEL) begin
                mode_sel_ff <= dat_i[3:0]; // R11
            end
            if (wr_stb && adr_i == `PCMS_OFF_IRQ_MASK) begin
                irq_mask_ff <= dat_i[1:0];
            end
        end
    end

    always @* begin
        nxt_dat = 32'h00000000;
        if (adr_i == `PCMS_OFF_SEL) begin
            nxt_dat[3:0] = mode_sel_ff;
        end else if (adr_i == `PCMS_OFF_ACC) begin
            nxt_dat[7:0] = acc_ff;
        end else if (adr_i == `PCMS_OFF_WKPND) begin
            nxt_dat[7:0] = wakeup_pending_portb_ff;
        end else if (adr_i == `PCMS_OFF_IRQ_ST) begin
            nxt_dat[1:0] = irq_st_ff;
        end else if (adr_i == `PCMS_OFF_IRQ_MASK) begin
            nxt_dat[1:0] = irq_mask_ff;
        end else if (adr_i == `PCMS_OFF_DIR) begin
            nxt_dat[7:0] = pin_direction_reg_o[15:8];
        end else if (adr_i == `PCMS_OFF_PULLUP) begin
            nxt_dat[7:0] = pullup_reg_o[15:8];
        end else if (adr_i == `PCMS_OFF_LEVEL) begin
            nxt_dat[7:0] = threshold_select_reg_o[15:8];
        end else if (adr_i == `PCMS_OFF_HYST) begin
            nxt_dat[7:0] = noise_immune_input_select_o[15:8];
        end else if (adr_i == `PCMS_OFF_WKEN) begin
            nxt_dat[7:0] = wakeup_enable_portb_o;
        end else if (adr_i == `PCMS_OFF_WKED) begin
            nxt_dat[7:0] = wakeup_edge_portb_o;
        end else if (adr_i == `PCMS_OFF_COMP) begin
            nxt_dat[7:0] = comp_ff;
        end
    end

    assign comparator_ctrl_o = comp_ff;
    assign irq_o = |(irq_st_ff & irq_mask_ff);
endmodule

// File: pcms_regs.vh
// port configuration constants: selector codes, wishbone offsets, reset values
// assumes 8-bit configuration data and a 32-bit wishbone data path
`ifndef PCMS_REGS_VH
`define PCMS_REGS_VH
`define PCMS_SEL_DIR 4'hF
`define PCMS_SEL_PULLUP 4'hE
`define PCMS_SEL_LEVEL 4'hD
`define PCMS_SEL_HYST 4'hC
`define PCMS_SEL_WKEN 4'hB
`define PCMS_SEL_WKED 4'hA
`define PCMS_SEL_WKPND 4'h9
`define PCMS_SEL_COMP 4'h8
`define PCMS_SEL_RST 4'hF
`define PCMS_DIR_RST 8'hFF
`define PCMS_PULLUP_RST 8'hFF
`define PCMS_LEVEL_RST 8'hFF
`define PCMS_HYST_RST 8'hFF
`define PCMS_WKEN_RST 8'hFF
`define PCMS_WKED_RST 8'h00
`define PCMS_COMP_RST 8'h00
`define PCMS_OFF_SEL 6'h00
`define PCMS_OFF_CMD 6'h04
`define PCMS_OFF_ACC 6'h08
`define PCMS_OFF_WKPND 6'h0C
`define PCMS_OFF_IRQ_ST 6'h10
`define PCMS_OFF_IRQ_MASK 6'h14
`define PCMS_OFF_DIR 6'h20
`define PCMS_OFF_PULLUP 6'h24
`define PCMS_OFF_LEVEL 6'h28
`define PCMS_OFF_HYST 6'h2C
`define PCMS_OFF_WKEN 6'h30
`define PCMS_OFF_WKED 6'h34
`define PCMS_OFF_COMP 6'h38
`define PCMS_PORTS 5
`define PCMS_PORT_B 3'h1
`define PCMS_COMP_BITS 8'h07
`endif

// File: pcms_cfg_reg.v
// one 8-bit port configuration register with a reset value
// assumes the caller decodes the write strobe
module pcms_cfg_reg #(
    parameter [7:0] RST_VAL = 8'hFF
) (
    input wire clk_i,
    input wire rst_i,
    input wire we_i,
    input wire [7:0] d_i,
    output wire [7:0] q_o
);
    reg [7:0] val_ff;
    always @(posedge clk_i) begin
        if (rst_i) begin
            val_ff <= RST_VAL;
        end else if (we_i) begin
            val_ff <= d_i;
        end
    end
    assign q_o = val_ff;
endmodule

// File: pcms_wake_det.v
// port b wake edge detector; sets pending bits on the chosen edge
// assumes pin levels already synchronous to clk_i
module pcms_wake_det (
    input wire clk_i,
    input wire rst_i,
    input wire [7:0] pin_i,
    input wire [7:0] en_n_i,
    input wire [7:0] edge_i,
    output wire [7:0] hit_o
);
    reg [7:0] prev_ff;
    always @(posedge clk_i) begin
        if (rst_i) begin
            prev_ff <= 8'h00;
        end else begin
            prev_ff <= pin_i;
        end
    end
    // edge bit 1 falling, 0 rising; enable is active low
    assign hit_o = ~en_n_i & ((edge_i & prev_ff & ~pin_i) | (~edge_i & ~prev_ff & pin_i));
endmodule

// File: pcms_top_assertions.sv
// checker for the port configuration selector, bound onto pcms_top
// assumes classic wishbone; mirrors the selector from acked bus writes
`include "pcms_regs.vh"
module pcms_chk (
    input wire clk_i,
    input wire rst_i,
    input wire cyc_i,
    input wire stb_i,
    input wire we_i,
    input wire [5:0] adr_i,
    input wire [3:0] sel_i,
    input wire [31:0] dat_i,
    input wire ack_o,
    input wire [39:0] pin_direction_reg_o,
    input wire [39:0] pullup_reg_o,
    input wire [39:0] threshold_select_reg_o,
    input wire [39:0] noise_immune_input_select_o,
    input wire [7:0] wakeup_enable_portb_o,
    input wire [7:0] wakeup_edge_portb_o,
    input wire [7:0] comparator_ctrl_o
);
    timeunit 1ns;
    timeprecision 100ps;
    reg [3:0] mode_ff;
    wire acc_wr = cyc_i && stb_i && we_i && ack_o && sel_i[0];
    wire any_cmd = acc_wr && adr_i == `PCMS_OFF_CMD;
    wire cmd_wr = any_cmd && dat_i[10:8] < 3'h5;
    wire [5:0] bo = {dat_i[10:8], 3'h0};
    wire [183:0] cfg_all = {pin_direction_reg_o, pullup_reg_o, threshold_select_reg_o,
        noise_immune_input_select_o, wakeup_enable_portb_o, wakeup_edge_portb_o,
        comparator_ctrl_o};
    always @(posedge clk_i) begin
        if (rst_i)
            mode_ff <= 4'hF;
        else if (acc_wr && adr_i == `PCMS_OFF_SEL)
            mode_ff <= dat_i[3:0];
    end
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    ack_answer_a: assert property (cyc_i && stb_i && !ack_o |=> ack_o)
        else $error("request not answered next cycle");
    ack_pulse_a: assert property (ack_o |=> !ack_o)
        else $error("ack longer than one cycle");
    dir_write_a: assert property (cmd_wr && mode_ff == 4'hF
        |=> pin_direction_reg_o[$past(bo) +: 8] == $past(dat_i[7:0]))
        else $error("direction byte not written");
    dir_only_a: assert property (cmd_wr && mode_ff == 4'hF
        |=> $stable({pullup_reg_o, threshold_select_reg_o}))
        else $error("direction write touched another register");
    pull_write_a: assert property (cmd_wr && mode_ff == 4'hE
        |=> pullup_reg_o[$past(bo) +: 8] == $past(dat_i[7:0]))
        else $error("pull-up byte not written");
    level_write_a: assert property (cmd_wr && mode_ff == 4'hD
        |=> threshold_select_reg_o[$past(bo) +: 8] == $past(dat_i[7:0]))
        else $error("threshold byte not written");
    porta_hyst_a: assert property (noise_immune_input_select_o[7:0] == 8'hFF)
        else $error("port a hysteresis byte changed");
    wake_enable_a: assert property (cmd_wr && mode_ff == 4'hB && dat_i[10:8] == 3'h1
        |=> wakeup_enable_portb_o == $past(dat_i[7:0]))
        else $error("wake enable not written");
    low_code_a: assert property (any_cmd && mode_ff < 4'h8 |=> $stable(cfg_all))
        else $error("low selector code changed a register");
    comp_bits_a: assert property (comparator_ctrl_o[7:3] == 5'h00)
        else $error("comparator bits above 2 set");
    cover property (cmd_wr && mode_ff == 4'hE);
    cover property (cmd_wr && mode_ff == 4'hB);
    cover property (any_cmd && mode_ff < 4'h8);
endmodule
bind pcms_top pcms_chk u_chk (.clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .adr_i, .sel_i, .dat_i,
    .ack_o, .pin_direction_reg_o, .pullup_reg_o, .threshold_select_reg_o,
    .noise_immune_input_select_o, .wakeup_enable_portb_o, .wakeup_edge_portb_o,
    .comparator_ctrl_o);

// File: pcms_top_tb.sv
// bench for the port configuration selector: reset, modes, port b, interrupt
// assumes the checker is bound; port b pin 3 pulsed once for a wake event
`include "pcms_regs.vh"
module pcms_top_tb;
    timeunit 1ns;
    timeprecision 100ps;
    logic clk_i = 0, rst_i = 1, cyc_i = 0, stb_i = 0, we_i = 0, ack_o, irq_o;
    logic [5:0] adr_i = 0;
    logic [3:0] sel_i = 0;
    logic [31:0] dat_i = 0, dat_o, q;
    logic [39:0] dir_o, pull_o, thr_o, nis_o, m [0:3];
    logic [7:0] wen_o, wedge_o, comp_o, v, pin = 0;
    int errors = 0, checks_done = 0, c, p, n;
    pcms_top dut (.clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .adr_i, .sel_i, .dat_i, .dat_o,
        .ack_o, .irq_o, .portb_pin_i(pin), .pin_direction_reg_o(dir_o),
        .pullup_reg_o(pull_o), .threshold_select_reg_o(thr_o),
        .noise_immune_input_select_o(nis_o), .wakeup_enable_portb_o(wen_o),
        .wakeup_edge_portb_o(wedge_o), .comparator_ctrl_o(comp_o));
    always #2.5 clk_i = ~clk_i;
    task automatic complete_run;
        $display("errors %0d checks %0d", errors, checks_done);
        if (errors == 0 && checks_done > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    task automatic chk(input logic [39:0] g, e);
        checks_done++;
        if (g !== e) begin
            errors++;
            $display("BAD %0t got %h want %h", $time, g, e);
        end
    endtask
    // request held until ack is seen, released at that same rising edge
    task automatic wb(input logic w, input logic [5:0] a, input logic [31:0] d);
        {cyc_i, stb_i, we_i, adr_i, dat_i, sel_i} <= {2'b11, w, a, d, 4'hF};
        n = 0;
        do @(posedge clk_i); while (ack_o !== 1'b1 && ++n < 20);
        if (n >= 20) begin
            errors++;
            complete_run();
        end
        q = dat_o;
        {cyc_i, stb_i} <= 2'b00;
        @(posedge clk_i);
    endtask
    task automatic cmd(input int pt, input logic [7:0] val);
        wb(1, `PCMS_OFF_CMD, {21'h0, pt[2:0], val});
    endtask
    task automatic t_reset;
        rst_i <= 1;
        repeat (3) @(posedge clk_i);
        rst_i <= 0;
        @(posedge clk_i);
        for (c = 0; c < 4; c++) m[c] = {5{8'hFF}};
        chk(dir_o, m[0]);
        chk(pull_o, m[1]);
        chk(thr_o, m[2]);
        chk(nis_o, m[3]);
        chk({wen_o, wedge_o, comp_o, irq_o}, 25'h1FE0000);
        wb(0, `PCMS_OFF_SEL, 0);
        chk(q[3:0], 4'hF);
    endtask
    // selector left at its reset code for the first pass
    task automatic t_modes;
        for (c = 15; c >= 12; c--) begin
            if (c != 15) wb(1, `PCMS_OFF_SEL, c);
            for (p = 0; p < 5; p++) begin
                v = {c[3:0], 1'b0, p[2:0]};
                cmd(p, v);
                if (c != 12 || p != 0) m[15 - c][8 * p +: 8] = v;
                chk(dir_o, m[0]);
                chk(pull_o, m[1]);
                chk(thr_o, m[2]);
                chk(nis_o, m[3]);
            end
        end
    endtask
    task automatic t_portb;
        wb(0, `PCMS_OFF_SEL, 0);
        chk(q[3:0], 4'hC);
        wb(1, `PCMS_OFF_SEL, 11);
        cmd(1, 8'hA5);
        cmd(2, 8'h3C);
        wb(1, `PCMS_OFF_SEL, 10);
        cmd(1, 8'h5A);
        chk({wen_o, wedge_o}, 16'hA55A);
        wb(1, `PCMS_OFF_ACC, 8'hC9);
        wb(1, `PCMS_OFF_SEL, 8);
        cmd(1, 8'h00);
        wb(0, `PCMS_OFF_ACC, 0);
        chk({comp_o, q[7:0]}, 16'h0100);
        wb(1, `PCMS_OFF_ACC, 8'h66);
        wb(1, `PCMS_OFF_SEL, 9);
        cmd(1, 8'h00);
        wb(0, `PCMS_OFF_ACC, 0);
        chk(q[7:0], 8'h00);
        wb(0, `PCMS_OFF_WKPND, 0);
        chk(q[7:0], 8'h66);
    endtask
    task automatic t_irq;
        for (c = 0; c < 8; c++) begin
            wb(1, `PCMS_OFF_SEL, c);
            cmd(1, 8'h00);
        end
        chk({dir_o, wen_o, wedge_o}, {m[0], 16'hA55A});
        // pin 3 is wake enabled for a falling edge
        pin <= 8'h08;
        repeat (2) @(posedge clk_i);
        pin <= 8'h00;
        repeat (2) @(posedge clk_i);
        wb(0, `PCMS_OFF_WKPND, 0);
        chk(q[7:0], 8'h6E);
        wb(0, 6'h10, 0);
        chk({q[1:0], irq_o}, 3'b110);
        wb(1, `PCMS_OFF_IRQ_MASK, 2);
        wb(0, 6'h10, 0);
        chk(irq_o, 1'b1);
        wb(1, 6'h10, 2);
        wb(0, 6'h3C, 0);
        chk({q, irq_o}, 33'h0);
    endtask
    initial begin
        t_reset();
        t_modes();
        t_portb();
        t_irq();
        t_reset();
        complete_run();
    end
endmodule
